// [hdl/dscr_core.sv]
// Serial control registers, volume autoramp and control decode of a stereo DAC
//
// What this block does
// - Frames are 16 bits, MSB first; low two bits select, upper 14 are data.
// - Select 01 goes to control, 00 to left volume, 10 to right volume.
// - A control write loads frame bits 13:2 into the 12-bit control word.
// - Upper ten gain bits step by one per sample period toward the target.
// - Lowest four volume bits apply at the next frame clock edge, bypassing the ramp.
// - The 14-bit volume is an unsigned linear multiplier; all ones is unity less one LSB step.
// - Data bits shift in on the rising serial control clock edge.
// - Latch rising edge transfers the shifted frame to the addressed register.
// - Serial clock may run between frames; unlatched edges have no effect.
// - New gain starts its ramp at the first frame clock edge after the latch.
// - Mute pin OR control bit 6 mutes both channels.
// - Mute ramps gain down; unmute ramps back to the volume register.
// - High de-emphasis pin enables the 44.1 kHz curve when the field is 00.
// - Control bits 3:2 pick de-emphasis: none, 44.1, 32, 48 kHz; default none.
// - While in reset, processing stops and outputs sit at midscale.
// - After reset release, output resumes after group delay plus three clocks.
// - Hardware reset forces every register, serial ones too, to defaults.
// - Control bit 7 holds processing at defaults but keeps register contents.
// - Bit 11 selects 2x, bit 10 4x interpolation, each ORed with its pin.
// - Bits 5:4 ORed with format pins select RJ, I2S, LJ or DSP format.
`timescale 1ns/1ps
module dscr_core #(
    parameter int GROUP_DELAY_CYCLES = dscr_pkg::DEF_GROUP_DELAY
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CTRL_SERIAL_CLOCK,
    input wire logic CTRL_SERIAL_IN,
    input wire logic CTRL_FRAME_LATCH,
    input wire logic FRAME_CLOCK,
    input wire logic MUTE_PIN,
    input wire logic DEEMPH_ENABLE_PIN,
    input wire logic FORMAT_SELECT_PIN_LO,
    input wire logic FORMAT_SELECT_PIN_HI,
    input wire logic RATE_2X_PIN,
    input wire logic RATE_4X_PIN,
    input wire logic signed [23:0] SAMPLE_IN_L,
    input wire logic signed [23:0] SAMPLE_IN_R,
    output logic signed [23:0] SAMPLE_OUT_L,
    output logic signed [23:0] SAMPLE_OUT_R,
    output logic [13:0] GAIN_L,
    output logic [13:0] GAIN_R,
    output logic [1:0] DEEMPH_SELECT,
    output logic [1:0] SERIAL_FORMAT,
    output logic [1:0] WORD_LENGTH,
    output logic INTERP_2X,
    output logic INTERP_4X,
    output logic MUTE_ACTIVE,
    output logic PROCESS_READY
);
    localparam int RELEASE_LIMIT = GROUP_DELAY_CYCLES + dscr_pkg::RELEASE_EXTRA_CYCLES;
    localparam logic [15:0] HOLD_LAST = 16'(RELEASE_LIMIT - 1);

    typedef struct packed {
        logic latch_s1;
        logic latch_s2;
        logic latch_d;
        logic frame_s1;
        logic frame_s2;
        logic frame_d;
        logic [5:0] pins_s1;
        logic [5:0] pins_s2;
        logic [13:0] left_vol;
        logic [13:0] right_vol;
        logic [11:0] ctrl;
        logic [13:0] gain_l;
        logic [13:0] gain_r;
        logic [15:0] hold_cnt;
        logic ready;
        logic [1:0] deemph;
        logic [1:0] format;
        logic [1:0] wlen;
        logic int2x;
        logic int4x;
        logic muted;
        logic [23:0] out_l;
        logic [23:0] out_r;
    } dscr_state_t;

    localparam dscr_state_t STATE_RESET = '{
        latch_s1: 1'b0, latch_s2: 1'b0, latch_d: 1'b0,
        frame_s1: 1'b0, frame_s2: 1'b0, frame_d: 1'b0,
        pins_s1: 6'h00, pins_s2: 6'h00,
        left_vol: dscr_pkg::GAIN_RESET,
        right_vol: dscr_pkg::GAIN_RESET,
        ctrl: dscr_pkg::CTRL_RESET,
        gain_l: dscr_pkg::APPLIED_RESET,
        gain_r: dscr_pkg::APPLIED_RESET,
        hold_cnt: 16'h0000, ready: 1'b0,
        deemph: 2'h0, format: 2'h0, wlen: 2'h0,
        int2x: 1'b0, int4x: 1'b0, muted: 1'b0,
        out_l: 24'h000000, out_r: 24'h000000
    };

    dscr_state_t st_reg;
    dscr_state_t st_next;
    logic [15:0] frame_word;
    logic latch_rise;
    logic frame_rise;
    logic soft_hold;
    logic mute_req;
    logic signed [38:0] prod_l;
    logic signed [38:0] prod_r;

    // ==========================================
    // Link-side shifter
    dscr_shift u_shift (
        .ctrl_serial_clock(CTRL_SERIAL_CLOCK),
        .rst(RST),
        .ctrl_serial_in(CTRL_SERIAL_IN),
        .frame_word(frame_word)
    );

    // ==========================================
    // Helpers
    function automatic logic [13:0] dscr_ramp(
        input logic [13:0] cur,
        input logic [13:0] vol,
        input logic mute
    );
        logic [9:0] hi;
        logic [9:0] tgt;
        hi = cur[13:4];
        tgt = mute ? 10'h000 : vol[13:4];
        if (hi < tgt) begin
            hi = hi + 10'h001;
        end else if (hi > tgt) begin
            hi = hi - 10'h001;
        end
        // Low nibble skips the ramp
        dscr_ramp = {hi, (mute ? 4'h0 : vol[3:0])};
    endfunction

    function automatic logic [23:0] dscr_scale(input logic signed [38:0] p);
        // Drop 14 fraction bits; all-ones gain is unity less one LSB step
        dscr_scale = p[37:14];
    endfunction

    // ==========================================
    // Next state
    assign latch_rise = st_reg.latch_s2 & ~st_reg.latch_d;
    assign frame_rise = st_reg.frame_s2 & ~st_reg.frame_d;
    assign soft_hold = st_reg.ctrl[dscr_pkg::CTRL_SOFT_RESET];
    assign mute_req = st_reg.pins_s2[dscr_pkg::PIN_MUTE] | st_reg.ctrl[dscr_pkg::CTRL_MUTE];
    assign prod_l = SAMPLE_IN_L * $signed({1'b0, st_reg.gain_l});
    assign prod_r = SAMPLE_IN_R * $signed({1'b0, st_reg.gain_r});

    always_comb begin
        st_next = st_reg;
        st_next.latch_s1 = CTRL_FRAME_LATCH;
        st_next.latch_s2 = st_reg.latch_s1;
        st_next.latch_d = st_reg.latch_s2;
        st_next.frame_s1 = FRAME_CLOCK;
        st_next.frame_s2 = st_reg.frame_s1;
        st_next.frame_d = st_reg.frame_s2;
        // Format pins may move anytime; the sync pair tames that
        st_next.pins_s1 = {RATE_4X_PIN, RATE_2X_PIN, FORMAT_SELECT_PIN_HI,
                           FORMAT_SELECT_PIN_LO, DEEMPH_ENABLE_PIN, MUTE_PIN};
        st_next.pins_s2 = st_reg.pins_s1;

        // Shifter output is quiet for a full serial half period after latch
        // rises, longer than the three-cycle sync, so sampling it here is safe
        if (latch_rise) begin
            case (frame_word[1:0])
                dscr_pkg::SEL_LEFT: begin
                    st_next.left_vol = frame_word[15:2];
                end
                dscr_pkg::SEL_CTRL: begin
                    st_next.ctrl = frame_word[13:2];
                end
                dscr_pkg::SEL_RIGHT: begin
                    st_next.right_vol = frame_word[15:2];
                end
                default: begin
                end
            endcase
        end

        // Soft reset keeps registers, clears processing
        if (soft_hold) begin
            st_next.gain_l = dscr_pkg::APPLIED_RESET;
            st_next.gain_r = dscr_pkg::APPLIED_RESET;
            st_next.hold_cnt = 16'h0000;
            st_next.ready = 1'b0;
        end else begin
            if (!st_reg.ready) begin
                st_next.hold_cnt = st_reg.hold_cnt + 16'h0001;
                st_next.ready = (st_reg.hold_cnt == HOLD_LAST);
            end
            if (frame_rise) begin
                st_next.gain_l = dscr_ramp(st_reg.gain_l, st_reg.left_vol, mute_req);
                st_next.gain_r = dscr_ramp(st_reg.gain_r, st_reg.right_vol, mute_req);
            end
        end

        // Nonzero field wins; otherwise the pin brings in the 44.1 curve
        if (st_reg.ctrl[3:2] != 2'b00) begin
            st_next.deemph = st_reg.ctrl[3:2];
        end else if (st_reg.pins_s2[dscr_pkg::PIN_DEEMPH]) begin
            st_next.deemph = dscr_pkg::DSCR_DEEMPH_44K;
        end else begin
            st_next.deemph = dscr_pkg::DSCR_DEEMPH_NONE;
        end
        st_next.format = st_reg.ctrl[5:4] | st_reg.pins_s2[3:2];
        st_next.wlen = st_reg.ctrl[9:8];
        st_next.int2x = st_reg.ctrl[dscr_pkg::CTRL_INT2X] | st_reg.pins_s2[dscr_pkg::PIN_RATE2X];
        st_next.int4x = st_reg.ctrl[dscr_pkg::CTRL_INT4X] | st_reg.pins_s2[dscr_pkg::PIN_RATE4X];
        st_next.muted = mute_req;

        if (st_reg.ready && !soft_hold) begin
            st_next.out_l = dscr_scale(prod_l);
            st_next.out_r = dscr_scale(prod_r);
        end else begin
            st_next.out_l = 24'h000000;
            st_next.out_r = 24'h000000;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // Outputs
    assign SAMPLE_OUT_L = st_reg.out_l;
    assign SAMPLE_OUT_R = st_reg.out_r;
    assign GAIN_L = st_reg.gain_l;
    assign GAIN_R = st_reg.gain_r;
    assign DEEMPH_SELECT = st_reg.deemph;
    assign SERIAL_FORMAT = st_reg.format;
    assign WORD_LENGTH = st_reg.wlen;
    assign INTERP_2X = st_reg.int2x;
    assign INTERP_4X = st_reg.int4x;
    assign MUTE_ACTIVE = st_reg.muted;
    assign PROCESS_READY = st_reg.ready;

    // ==========================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_latch_to(logic [1:0] sel);
        latch_rise && frame_word[1:0] == sel;
    endsequence

    sequence s_soft_release;
        $fell(soft_hold);
    endsequence

    chk_route_left_vol: assert property (
        s_latch_to(dscr_pkg::SEL_LEFT) |=> st_reg.left_vol == $past(frame_word[15:2]))
        else $error("left volume not loaded from frame");

    chk_route_right_vol: assert property (
        s_latch_to(dscr_pkg::SEL_RIGHT) |=> st_reg.right_vol == $past(frame_word[15:2])
            && $stable(st_reg.left_vol))
        else $error("right volume write misrouted");

    chk_route_ctrl_word: assert property (
        s_latch_to(dscr_pkg::SEL_CTRL) |=> st_reg.ctrl == $past(frame_word[13:2])
            && $stable(st_reg.right_vol))
        else $error("control word not loaded");

    chk_no_latch_hold: assert property (
        !latch_rise |=> $stable(st_reg.ctrl) && $stable(st_reg.left_vol))
        else $error("register changed without latch");

    chk_ramp_single_step: assert property (
        !frame_rise |=> $stable(GAIN_L[13:4]) || $past(soft_hold))
        else $error("gain moved outside a frame edge");

    chk_ramp_toward: assert property (
        frame_rise && !soft_hold && !mute_req && GAIN_L[13:4] < st_reg.left_vol[13:4]
            |=> GAIN_L[13:4] == $past(GAIN_L[13:4]) + 10'h001)
        else $error("gain did not step up by one");

    chk_low_bits_direct: assert property (
        frame_rise && !soft_hold && !mute_req |=> GAIN_R[3:0] == $past(st_reg.right_vol[3:0]))
        else $error("low gain bits not applied directly");

    chk_mute_ramps_down: assert property (
        frame_rise && mute_req && !soft_hold && GAIN_L[13:4] != 10'h000
            |=> GAIN_L[13:4] == $past(GAIN_L[13:4]) - 10'h001)
        else $error("muted gain did not ramp down");

    chk_mute_or_pin: assert property (
        ##1 MUTE_ACTIVE == $past(st_reg.pins_s2[0] | st_reg.ctrl[6]))
        else $error("mute not the OR of pin and bit");

    chk_format_or_pins: assert property (
        ##1 SERIAL_FORMAT == $past(st_reg.ctrl[5:4] | st_reg.pins_s2[3:2]))
        else $error("serial format not ORed with pins");

    chk_deemph_pin: assert property (
        st_reg.pins_s2[1] && st_reg.ctrl[3:2] == 2'b00 |=> DEEMPH_SELECT == 2'b01)
        else $error("de-emphasis pin ignored");

    chk_midscale_hold: assert property (
        !PROCESS_READY |=> SAMPLE_OUT_L == 24'h000000 && SAMPLE_OUT_R == 24'h000000)
        else $error("output not midscale during reset");

    chk_release_delay: assert property (
        s_soft_release |-> !PROCESS_READY [*3])
        else $error("processing resumed too early");

    chk_release_count: assert property (
        $rose(PROCESS_READY) |-> $past(st_reg.hold_cnt) == HOLD_LAST)
        else $error("ready rose at wrong count");

    chk_soft_keeps_regs: assert property (
        soft_hold && !latch_rise |=> $stable(st_reg.left_vol) && GAIN_L == 14'h0000)
        else $error("soft reset disturbed registers");

    chk_unused_select: assert property (
        s_latch_to(2'h3) |=> $stable(st_reg.left_vol) && $stable(st_reg.right_vol) && $stable(st_reg.ctrl))
        else $error("select 11 changed a register");

    chk_wlen_follows: assert property (
        ##1 WORD_LENGTH == $past(st_reg.ctrl[9:8]))
        else $error("word length not taken from control bits");

    chk_interp_or_pin: assert property (
        ##1 INTERP_2X == $past(st_reg.ctrl[11] | st_reg.pins_s2[4])
            && INTERP_4X == $past(st_reg.ctrl[10] | st_reg.pins_s2[5]))
        else $error("interpolation not ORed with pins");

    chk_deemph_field: assert property (
        st_reg.ctrl[3:2] != 2'b00 |=> DEEMPH_SELECT == $past(st_reg.ctrl[3:2]))
        else $error("de-emphasis field not applied");

    chk_ready_holds: assert property (
        PROCESS_READY && !soft_hold |=> PROCESS_READY)
        else $error("ready dropped without reset");
endmodule

// [hdl/dscr_pkg.sv]
// Constants shared by the serial control register block
package dscr_pkg;
    // ==========================================
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int GAIN_W = 14;
    localparam int GAIN_HI_LSB = 4;
    localparam int CTRL_W = 12;
    localparam logic [1:0] SEL_LEFT = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h1;
    localparam logic [1:0] SEL_RIGHT = 2'h2;

    // ==========================================
    // Control field positions
    localparam int CTRL_INT2X = 11;
    localparam int CTRL_INT4X = 10;
    localparam int CTRL_WLEN_LSB = 8;
    localparam int CTRL_SOFT_RESET = 7;
    localparam int CTRL_MUTE = 6;
    localparam int CTRL_FMT_LSB = 4;
    localparam int CTRL_DEEMPH_LSB = 2;

    // ==========================================
    // Pin vector positions
    localparam int PIN_MUTE = 0;
    localparam int PIN_DEEMPH = 1;
    localparam int PIN_FMT_LO = 2;
    localparam int PIN_FMT_HI = 3;
    localparam int PIN_RATE2X = 4;
    localparam int PIN_RATE4X = 5;
    localparam int PIN_W = 6;

    // ==========================================
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 14'h3FFF;
    localparam logic [GAIN_W-1:0] APPLIED_RESET = 14'h0000;
    localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;

    // ==========================================
    // Timing counts in master clock cycles
    localparam int DEF_GROUP_DELAY = 64;
    localparam int RELEASE_EXTRA_CYCLES = 3;
    localparam int MIN_RESET_CYCLES = 64;

    // ==========================================
    // Field encodings
    typedef enum logic [1:0] {
        DSCR_DEEMPH_NONE = 2'b00,
        DSCR_DEEMPH_44K = 2'b01,
        DSCR_DEEMPH_32K = 2'b10,
        DSCR_DEEMPH_48K = 2'b11
    } dscr_deemph_t;
    typedef enum logic [1:0] {
        DSCR_FMT_RJ = 2'b00,
        DSCR_FMT_I2S = 2'b01,
        DSCR_FMT_LJ = 2'b10,
        DSCR_FMT_DSP = 2'b11
    } dscr_format_t;
    typedef enum logic [1:0] {
        DSCR_WLEN_24 = 2'b00,
        DSCR_WLEN_20 = 2'b01,
        DSCR_WLEN_16 = 2'b10
    } dscr_wlen_t;
endpackage

// [hdl/dscr_shift.sv]
// Serial-to-parallel shifter on the control serial clock
`timescale 1ns/1ps
module dscr_shift (
    input wire logic ctrl_serial_clock,
    input wire logic rst,
    input wire logic ctrl_serial_in,
    output logic [15:0] frame_word
);
    typedef struct packed {
        logic [15:0] shift;
    } dscr_shift_state_t;

    dscr_shift_state_t st_reg;
    dscr_shift_state_t st_next;

    // ==========================================
    // Shifter
    always_comb begin
        st_next = st_reg;
        // MSB first: oldest bit ends at the top
        st_next.shift = {st_reg.shift[14:0], ctrl_serial_in};
    end

    always_ff @(posedge ctrl_serial_clock or posedge rst) begin
        if (rst) begin
            st_reg <= '{shift: dscr_pkg::SHIFT_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign frame_word = st_reg.shift;

    // One edge of history first: the edge right after reset has nothing to compare with
    chk_shift_msb_first: assert property (@(posedge ctrl_serial_clock) disable iff (rst)
        ##1 frame_word[15:1] == $past(frame_word[14:0]))
        else $error("shift register did not move up one place");
endmodule

// [tb/dscr_host_model.sv]
// Host controller model driving the three-wire control port
`timescale 1ns/1ps
module dscr_host_model (
    output logic ctrl_serial_clock,
    output logic ctrl_serial_in,
    output logic ctrl_frame_latch
);
    // ==========================================
    // Link timebase, 32 ns period, free of the master clock phase
    logic link_tick;

    initial begin
        link_tick = 1'b0;
        ctrl_serial_clock = 1'b0;
        ctrl_serial_in = 1'b0;
        ctrl_frame_latch = 1'b0;
        #3.7;
        forever #16 link_tick = ~link_tick;
    end

    // ==========================================
    // One frame, sixteen bits, optionally without the latch
    task automatic shift_bits(input logic [15:0] word, input logic do_latch);
        for (int i = 15; i >= 0; i--) begin
            @(negedge link_tick);
            ctrl_serial_clock <= 1'b0;
            ctrl_serial_in <= word[i];
            @(posedge link_tick);
            ctrl_serial_clock <= 1'b1;
        end
        @(negedge link_tick);
        ctrl_serial_clock <= 1'b0;
        ctrl_frame_latch <= do_latch;
        // Line is undriven after the frame, so show a changed level, not a held one
        ctrl_serial_in <= ~word[0];
        // Latch held long enough for the master-clock side to sample the shifter
        repeat (2) @(negedge link_tick);
        ctrl_frame_latch <= 1'b0;
        repeat (2) @(negedge link_tick);
    endtask
endmodule

// [tb/dscr_core_tb_top.sv]
// Self-checking testbench of the serial control register block
`timescale 1ns/1ps
`define DSCR_CHECK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end
module dscr_core_tb_top;
    localparam int GD = 4;
    logic clk, rst, frame_clock, frame_run;
    logic mute_pin, deemph_pin, fmt_lo, fmt_hi, rate2x, rate4x;
    logic [3:0] fdiv;
    logic signed [23:0] sample_in_l, sample_in_r, sample_out_l, sample_out_r;
    logic [13:0] gain_l, gain_r;
    logic [1:0] deemph_sel, ser_fmt, word_len;
    logic interp2x, interp4x, mute_active, ready;
    logic scl, sdi, slatch;
    int fail_count = 0;
    int n_compared = 0;

    dscr_host_model u_dscr_host_model (
        .ctrl_serial_clock(scl), .ctrl_serial_in(sdi), .ctrl_frame_latch(slatch));

    dscr_core #(.GROUP_DELAY_CYCLES(GD)) u_dscr_core (
        .CLK(clk), .RST(rst), .CTRL_SERIAL_CLOCK(scl), .CTRL_SERIAL_IN(sdi),
        .CTRL_FRAME_LATCH(slatch), .FRAME_CLOCK(frame_clock), .MUTE_PIN(mute_pin),
        .DEEMPH_ENABLE_PIN(deemph_pin), .FORMAT_SELECT_PIN_LO(fmt_lo),
        .FORMAT_SELECT_PIN_HI(fmt_hi), .RATE_2X_PIN(rate2x), .RATE_4X_PIN(rate4x),
        .SAMPLE_IN_L(sample_in_l), .SAMPLE_IN_R(sample_in_r), .SAMPLE_OUT_L(sample_out_l),
        .SAMPLE_OUT_R(sample_out_r), .GAIN_L(gain_l), .GAIN_R(gain_r),
        .DEEMPH_SELECT(deemph_sel), .SERIAL_FORMAT(ser_fmt), .WORD_LENGTH(word_len),
        .INTERP_2X(interp2x), .INTERP_4X(interp4x), .MUTE_ACTIVE(mute_active),
        .PROCESS_READY(ready));

    // ==========================================
    // Clocks; the frame clock parks low so single sample periods can be stepped
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (frame_run || fdiv != 4'h0) begin
            fdiv <= fdiv + 4'h1;
        end
        frame_clock <= fdiv[3];
    end

    // ==========================================
    // Helpers
    function automatic logic [23:0] scaled(input logic [23:0] s, input logic [13:0] g);
        scaled = 24'(({14'h0000, s} * {24'h000000, g}) >> 14);
    endfunction

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic write_reg(input logic [1:0] sel, input logic [13:0] content);
        u_dscr_host_model.shift_bits({content, sel}, 1'b1);
        wait_clk(4);
    endtask

    task automatic one_frame();
        @(posedge clk) frame_run <= 1'b1;
        @(posedge clk) frame_run <= 1'b0;
        wait_clk(24);
    endtask

    task automatic check_ctrl(input logic [1:0] de, fm, wl, input logic i2, i4, mu);
        `DSCR_CHECK("deemphasis", de, deemph_sel)
        `DSCR_CHECK("format", fm, ser_fmt)
        `DSCR_CHECK("word length", wl, word_len)
        `DSCR_CHECK("interp 2x", i2, interp2x)
        `DSCR_CHECK("interp 4x", i4, interp4x)
        `DSCR_CHECK("mute", mu, mute_active)
    endtask

    task automatic do_reset(input int n);
        @(posedge clk) rst <= 1'b1;
        wait_clk(n);
        `DSCR_CHECK("output in reset", 24'h000000, sample_out_l)
        @(posedge clk) rst <= 1'b0;
        wait_clk(GD);
        `DSCR_CHECK("ready early", 1'b0, ready)
        wait_clk(4);
        `DSCR_CHECK("ready", 1'b1, ready)
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Watchdog, well beyond the roughly 4700 cycles the sequence needs
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    // ==========================================
    // Main sequence
    initial begin
        logic [1:0] i, wl;
        rst = 1'b1;
        frame_run = 1'b1;
        fdiv = 4'h0;
        frame_clock = 1'b0;
        {mute_pin, deemph_pin, fmt_lo, fmt_hi, rate2x, rate4x} = 6'h00;
        sample_in_l = 24'h100000;
        sample_in_r = 24'h7FFFFF;
        do_reset(16);
        write_reg(dscr_pkg::SEL_RIGHT, 14'h0013);
        write_reg(dscr_pkg::SEL_LEFT, 14'h0025);
        wait_clk(640);
        `DSCR_CHECK("gain left", 14'h0025, gain_l)
        `DSCR_CHECK("gain right", 14'h0013, gain_r)
        `DSCR_CHECK("out left", scaled(24'h100000, 14'h0025), sample_out_l)
        `DSCR_CHECK("out right", scaled(24'h7FFFFF, 14'h0013), sample_out_r)
        // Unlatched clocks and the unused select must leave everything alone
        u_dscr_host_model.shift_bits({14'h3FFF, dscr_pkg::SEL_LEFT}, 1'b0);
        write_reg(2'h3, 14'h0000);
        wait_clk(200);
        `DSCR_CHECK("gain left kept", 14'h0025, gain_l)
        `DSCR_CHECK("gain right kept", 14'h0013, gain_r)
        for (int k = 0; k < 4; k++) begin
            i = 2'(k);
            wl = (i == 2'h3) ? 2'h0 : i;
            write_reg(dscr_pkg::SEL_CTRL, {2'h3, i[0], i[1], wl, 2'h0, i, i, 2'h0});
            check_ctrl(i, i, wl, i[0], i[1], 1'b0);
        end
        write_reg(dscr_pkg::SEL_CTRL, 14'h0000);
        @(posedge clk) mute_pin <= 1'b1;
        @(posedge clk) {deemph_pin, fmt_hi, rate2x} <= 3'h7;
        wait_clk(10);
        check_ctrl(2'h1, 2'h2, 2'h0, 1'b1, 1'b0, 1'b1);
        @(posedge clk) {mute_pin, fmt_hi, rate2x, fmt_lo, rate4x} <= 5'h03;
        write_reg(dscr_pkg::SEL_CTRL, 14'h0008);
        check_ctrl(2'h2, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0);
        @(posedge clk) {deemph_pin, fmt_lo, rate4x} <= 3'h0;
        write_reg(dscr_pkg::SEL_CTRL, 14'h0000);
        wait_clk(200);
        // Stepping the frame clock by hand makes each ramp step observable
        @(posedge clk) frame_run <= 1'b0;
        wait_clk(40);
        write_reg(dscr_pkg::SEL_LEFT, {10'h005, 4'hA});
        `DSCR_CHECK("gain before frame", 14'h0025, gain_l)
        for (int k = 1; k <= 4; k++) begin
            one_frame();
            `DSCR_CHECK("ramp step", {10'(2 + ((k > 3) ? 3 : k)), 4'hA}, gain_l)
        end
        write_reg(dscr_pkg::SEL_CTRL, 14'h0040);
        `DSCR_CHECK("soft mute", 1'b1, mute_active)
        one_frame();
        `DSCR_CHECK("mute ramp", {10'h004, 4'h0}, gain_l)
        repeat (4) one_frame();
        `DSCR_CHECK("muted gain", 14'h0000, gain_l)
        `DSCR_CHECK("muted out", 24'h000000, sample_out_l)
        write_reg(dscr_pkg::SEL_CTRL, 14'h0000);
        repeat (5) one_frame();
        `DSCR_CHECK("unmuted gain", {10'h005, 4'hA}, gain_l)
        write_reg(dscr_pkg::SEL_CTRL, 14'h0080);
        `DSCR_CHECK("soft reset ready", 1'b0, ready)
        `DSCR_CHECK("soft reset gain", 14'h0000, gain_l)
        `DSCR_CHECK("soft reset out", 24'h000000, sample_out_l)
        write_reg(dscr_pkg::SEL_CTRL, 14'h0000);
        wait_clk(20);
        `DSCR_CHECK("ready after soft", 1'b1, ready)
        repeat (8) one_frame();
        `DSCR_CHECK("volume kept", {10'h005, 4'hA}, gain_l)
        `DSCR_CHECK("out scaled", scaled(24'h100000, 14'h005A), sample_out_l)
        write_reg(dscr_pkg::SEL_CTRL, {2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 4'h4});
        do_reset(64);
        check_ctrl(2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0);
        `DSCR_CHECK("gain after reset", 14'h0000, gain_l)
        complete_run();
    end
endmodule
